/* File: logic/rsdp_core.v */
/*
 * Serial data port timing logic: register file, turnaround delay, serial
 * clock generation, frame sync, receive data launch, transmit data capture,
 * packet interrupt and PA shutdown timing.
 * Assumes register writes arrive as a one-cycle strobe with address and data
 * on sys_clk; radio status events are one-cycle pulses on sys_clk; the
 * transmit data pin comes from outside and is synchronised here.
 */
// Summary of operation
// - Packet-received interrupt rises 38 us after a complete frame.
// - PAN mode turnaround delay is 192 us.
// - GFSK/FSK turnaround delay is at least 664 us.
// - Serial clock stops 14 us after phy-ready command.
// - PA output shuts down 10 us after phy-ready during transmit.
// - Serial clock period equals one symbol period.
// - Frame sync rises five symbol periods after sync word detection.
// - Frame sync rises half a symbol minus up to 60 ns before active edge; the code leads the rising edge by half a symbol plus 100 ns.
// - Valid data follows clock start by sync word length symbols.
// - Receive with calibration starts serial clock 105 us later.
// - Transmit clock starts 1.3 to 6.2 us after PA reaches power.
// - Mode 2 with pin function 1 gives bit clock and bit data.
// - Mode 0 with pin function 7 gives symbol clock and data.
// - Serial transmit mode 3 samples rising edge for 1, falling for 4.
// - Pin functions 1 and 4 keep pins active through receive.
// - Pin functions 2 and 5 gate pins on preamble detection.
// - Pin functions 3 and 6 gate pins on sync word detection.
// - Functions 1-3 launch data on falling edge, 4-6 on rising.
// - Turnaround extension resets to zero and applies to receive and transmit.
`timescale 1ns/1ps
`include "rsdp_regs.vh"

module rsdp_core #(
	parameter SYM_CYC = 20,
	parameter SYNC_LEN = 16
) (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Register access
	input wire reg_wr,
	input wire [11:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_ff,
	// Radio commands and events
	input wire pan_mode,
	input wire transmit_command,
	input wire receive_command,
	input wire phy_ready_command,
	input wire pa_nominal,
	input wire frame_done,
	input wire preamble_det,
	input wire sync_det,
	input wire rx_bit,
	// Serial pins
	input wire serial_tx_data_in,
	output reg serial_rx_data_out_ff,
	output reg serial_data_clock_out_ff,
	output reg frame_sync_out_ff,
	// Status outputs
	output reg pkt_irq_ff,
	output reg pa_on_ff,
	output reg tx_state_ff,
	output reg rx_state_ff,
	output reg data_valid_ff,
	output reg tx_bit_valid_ff,
	output reg tx_bit_ff
);

	localparam ST_IDLE = 3'h0;
	localparam ST_TURN = 3'h1;
	localparam ST_RXCAL = 3'h2;
	localparam ST_RX = 3'h3;
	localparam ST_PARAMP = 3'h4;
	localparam ST_TX = 3'h5;
	localparam ST_STOP = 3'h6;

	reg [7:0] turn_ext_ff;
	reg [7:0] ctrl_cfg_ff;
	reg [7:0] pin_func_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [16:0] tmr_ff;
	reg [16:0] nxt_tmr;
	reg going_tx_ff;
	reg [15:0] irq_cnt_ff;
	reg irq_arm_ff;
	reg [15:0] pa_cnt_ff;
	reg pa_arm_ff;
	reg [15:0] div_ff;
	reg gate_open_ff;
	reg [15:0] fs_cnt_ff;
	reg fs_arm_ff;
	reg [15:0] valid_cnt_ff;
	reg din_s1_ff;
	reg din_s2_ff;

	wire [2:0] pf_lo = pin_func_ff[2:0];
	wire serial_mode = ctrl_cfg_ff == `RSDP_MODE_SERIAL;
	wire launch_rise = (pf_lo == 3'h4) || (pf_lo == 3'h5) || (pf_lo == 3'h6);
	wire half_pt = div_ff == (SYM_CYC / 2 - 1);
	wire full_pt = div_ff == (SYM_CYC - 1);
	// Serial port is in a documented receive configuration
	wire rx_cfg_ok = (ctrl_cfg_ff == `RSDP_MODE_BIT && pin_func_ff == `RSDP_PF_RISE_NOGATE) ||
		(ctrl_cfg_ff == `RSDP_MODE_SYM && pin_func_ff == `RSDP_PF_SYMBOL) ||
		(serial_mode && pf_lo >= 3'h1 && pf_lo <= 3'h6);
	wire clk_run = (state_ff == ST_RX && gate_open_ff && rx_cfg_ok) || (state_ff == ST_TX) ||
		(state_ff == ST_STOP && tmr_ff != 17'h0);

	// Cycle counts cut on purpose to the timer and counter widths
	function [16:0] cyc17;
		input integer n;
		cyc17 = n[16:0];
	endfunction
	function [15:0] cyc16;
		input integer n;
		cyc16 = n[15:0];
	endfunction
	function [16:0] us_cyc;
		input [9:0] us;
		us_cyc = cyc17(us * `RSDP_CYC_US);
	endfunction

	// Register file
	always @(posedge sys_clk) begin
		if (srst) begin
			turn_ext_ff <= `RSDP_RST_TURNAROUND_EXT;
			ctrl_cfg_ff <= `RSDP_RST_CTRL_CFG;
			pin_func_ff <= `RSDP_RST_PIN_FUNC;
			reg_rdata_ff <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `RSDP_OFS_TURNAROUND_EXT)
				turn_ext_ff <= reg_wdata;
			if (reg_wr && reg_addr == `RSDP_OFS_CTRL_CFG)
				ctrl_cfg_ff <= reg_wdata;
			if (reg_wr && reg_addr == `RSDP_OFS_PIN_FUNC)
				pin_func_ff <= reg_wdata;
			case (reg_addr)
				`RSDP_OFS_TURNAROUND_EXT: reg_rdata_ff <= turn_ext_ff;
				`RSDP_OFS_CTRL_CFG: reg_rdata_ff <= ctrl_cfg_ff;
				`RSDP_OFS_PIN_FUNC: reg_rdata_ff <= pin_func_ff;
				default: reg_rdata_ff <= {5'h00, state_ff};
			endcase
		end
	end

	// Radio sequencing
	always @* begin
		nxt_state = state_ff;
		nxt_tmr = (tmr_ff != 17'h0) ? tmr_ff - 17'h1 : 17'h0;
		case (state_ff)
			ST_IDLE: begin
				if (transmit_command || receive_command) begin
					nxt_state = ST_TURN;
					nxt_tmr = pan_mode ? cyc17(`RSDP_CYC_TA_PAN) : cyc17(`RSDP_CYC_TA_FSK);
				end
			end
			ST_TURN: begin
				// Extension is read at the end, so writes made during the turnaround still apply
				if (phy_ready_command)
					nxt_state = ST_IDLE;
				else if (tmr_ff == 17'h0) begin
					nxt_state = going_tx_ff ? ST_PARAMP : ST_RXCAL;
					nxt_tmr = us_cyc({2'h0, turn_ext_ff}) + (going_tx_ff ? 17'h0 : cyc17(`RSDP_CYC_RXCAL));
				end
			end
			ST_RXCAL: begin
				if (phy_ready_command) begin
					nxt_state = ST_STOP;
					nxt_tmr = cyc17(`RSDP_CYC_CLKOFF);
				end else if (tmr_ff == 17'h0)
					nxt_state = ST_RX;
			end
			ST_RX, ST_TX: begin
				if (phy_ready_command) begin
					nxt_state = ST_STOP;
					nxt_tmr = cyc17(`RSDP_CYC_CLKOFF);
				end
			end
			ST_PARAMP: begin
				// Cancel wins over the start of transmit
				if (phy_ready_command)
					nxt_state = ST_IDLE;
				else if (tmr_ff == 17'h1 && pa_on_ff)
					nxt_state = ST_TX;
				else if (pa_nominal && tmr_ff == 17'h0)
					nxt_tmr = cyc17(`RSDP_CYC_TXSTART);
			end
			ST_STOP: begin
				if (tmr_ff == 17'h0)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			tmr_ff <= 17'h0;
			going_tx_ff <= 1'b0;
			tx_state_ff <= 1'b0;
			rx_state_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			if (state_ff == ST_IDLE)
				going_tx_ff <= transmit_command;
			tx_state_ff <= nxt_state == ST_TX;
			rx_state_ff <= nxt_state == ST_RX;
		end
	end

	// PA enable and delayed shutdown after phy-ready
	always @(posedge sys_clk) begin
		if (srst) begin
			pa_on_ff <= 1'b0;
			pa_arm_ff <= 1'b0;
			pa_cnt_ff <= 16'h0;
		end else begin
			if (state_ff == ST_PARAMP && tmr_ff == 17'h0)
				pa_on_ff <= 1'b1;
			if (phy_ready_command && pa_on_ff) begin
				pa_arm_ff <= 1'b1;
				pa_cnt_ff <= cyc16(`RSDP_CYC_PAOFF - 1);
			end else if (pa_arm_ff) begin
				if (pa_cnt_ff == 16'h0) begin
					pa_arm_ff <= 1'b0;
					pa_on_ff <= 1'b0;
				end else
					pa_cnt_ff <= pa_cnt_ff - 16'h1;
			end
		end
	end

	// Packet received interrupt, one-cycle pulse
	always @(posedge sys_clk) begin
		if (srst) begin
			irq_arm_ff <= 1'b0;
			irq_cnt_ff <= 16'h0;
			pkt_irq_ff <= 1'b0;
		end else begin
			pkt_irq_ff <= 1'b0;
			if (frame_done) begin
				irq_arm_ff <= 1'b1;
				irq_cnt_ff <= cyc16(`RSDP_CYC_IRQ - 1);
			end else if (irq_arm_ff) begin
				if (irq_cnt_ff == 16'h0) begin
					irq_arm_ff <= 1'b0;
					pkt_irq_ff <= 1'b1;
				end else
					irq_cnt_ff <= irq_cnt_ff - 16'h1;
			end
		end
	end

	// Symbol divider, gating and serial clock
	always @(posedge sys_clk) begin
		if (srst) begin
			div_ff <= 16'h0;
			gate_open_ff <= 1'b0;
			serial_data_clock_out_ff <= 1'b0;
			serial_rx_data_out_ff <= 1'b0;
		end else begin
			div_ff <= (!clk_run || full_pt) ? 16'h0 : div_ff + 16'h1;
			if (state_ff != ST_RX)
				gate_open_ff <= 1'b0;
			else if (!serial_mode || pf_lo == 3'h1 || pf_lo == 3'h4)
				gate_open_ff <= 1'b1;
			else if ((pf_lo == 3'h2 || pf_lo == 3'h5) && preamble_det)
				gate_open_ff <= 1'b1;
			else if ((pf_lo == 3'h3 || pf_lo == 3'h6) && sync_det)
				gate_open_ff <= 1'b1;
			// Clock high in first half, low in second half
			serial_data_clock_out_ff <= clk_run && (div_ff < (SYM_CYC / 2));
			if (clk_run && state_ff == ST_RX && (launch_rise ? full_pt : half_pt))
				serial_rx_data_out_ff <= rx_bit;
		end
	end

	// Frame sync and data valid
	always @(posedge sys_clk) begin
		if (srst) begin
			fs_arm_ff <= 1'b0;
			fs_cnt_ff <= 16'h0;
			frame_sync_out_ff <= 1'b0;
			valid_cnt_ff <= 16'h0;
			data_valid_ff <= 1'b0;
		end else begin
			if (state_ff != ST_RX) begin
				fs_arm_ff <= 1'b0;
				frame_sync_out_ff <= 1'b0;
			end else if (sync_det) begin
				fs_arm_ff <= 1'b1;
				fs_cnt_ff <= cyc16(`RSDP_FS_SYMS * SYM_CYC - SYM_CYC / 2);
			end else if (fs_arm_ff) begin
				// Rises one cycle before mid symbol, half a period plus one cycle before the rising edge
				if (fs_cnt_ff == 16'h0 && half_pt) begin
					fs_arm_ff <= 1'b0;
					frame_sync_out_ff <= 1'b1;
				end else if (fs_cnt_ff != 16'h0)
					fs_cnt_ff <= fs_cnt_ff - 16'h1;
			end
			if (!(clk_run && state_ff == ST_RX)) begin
				valid_cnt_ff <= cyc16(SYNC_LEN * SYM_CYC);
				data_valid_ff <= 1'b0;
			end else if (valid_cnt_ff != 16'h0)
				valid_cnt_ff <= valid_cnt_ff - 16'h1;
			else
				data_valid_ff <= 1'b1;
		end
	end

	// Transmit data capture on selected edge
	always @(posedge sys_clk) begin
		if (srst) begin
			din_s1_ff <= 1'b0;
			din_s2_ff <= 1'b0;
			tx_bit_ff <= 1'b0;
			tx_bit_valid_ff <= 1'b0;
		end else begin
			din_s1_ff <= serial_tx_data_in;
			din_s2_ff <= din_s1_ff;
			tx_bit_valid_ff <= 1'b0;
			if (state_ff == ST_TX && serial_mode && ((pf_lo == 3'h4) ? half_pt : full_pt)) begin
				tx_bit_ff <= din_s2_ff;
				tx_bit_valid_ff <= 1'b1;
			end
		end
	end

endmodule // rsdp_core

/* File: logic/rsdp_regs.vh */
/*
 * Register offsets, field codes and timing counts for the radio serial data
 * port timing block. Assumes a 10 MHz system clock (100 ns period).
 */
`ifndef RSDP_REGS_VH
`define RSDP_REGS_VH

// Register offsets
`define RSDP_OFS_TURNAROUND_EXT 12'h10b
`define RSDP_OFS_CTRL_CFG 12'h13e
`define RSDP_OFS_PIN_FUNC 12'h32c

// Reset values
`define RSDP_RST_TURNAROUND_EXT 8'h00
`define RSDP_RST_CTRL_CFG 8'h00
`define RSDP_RST_PIN_FUNC 8'h00

// Controller operating mode codes
`define RSDP_MODE_SYM 8'h00
`define RSDP_MODE_BIT 8'h02
`define RSDP_MODE_SERIAL 8'h03

// Pin function codes
`define RSDP_PF_RISE_NOGATE 8'h01
`define RSDP_PF_FALL_PRE 8'h02
`define RSDP_PF_FALL_SYNC 8'h03
`define RSDP_PF_RISE_ALT 8'h04
`define RSDP_PF_ALT_PRE 8'h05
`define RSDP_PF_ALT_SYNC 8'h06
`define RSDP_PF_SYMBOL 8'h07

// Clock period and times
`define RSDP_CLK_NS 100
`define RSDP_T_IRQ_US 38
`define RSDP_T_TA_PAN_US 192
`define RSDP_T_TA_FSK_US 664
`define RSDP_T_CLKOFF_US 14
`define RSDP_T_PAOFF_US 10
`define RSDP_T_RXCAL_US 105
`define RSDP_T_TXSTART_MIN_NS 1300
`define RSDP_T_FS_LEAD_NS 60
`define RSDP_FS_SYMS 5

// Cycle counts: typical and longest round down, least rounds up
`define RSDP_CYC_IRQ ((`RSDP_T_IRQ_US * 1000) / `RSDP_CLK_NS)
`define RSDP_CYC_TA_PAN ((`RSDP_T_TA_PAN_US * 1000) / `RSDP_CLK_NS)
`define RSDP_CYC_TA_FSK ((`RSDP_T_TA_FSK_US * 1000 + `RSDP_CLK_NS - 1) / `RSDP_CLK_NS)
`define RSDP_CYC_CLKOFF ((`RSDP_T_CLKOFF_US * 1000) / `RSDP_CLK_NS)
`define RSDP_CYC_PAOFF ((`RSDP_T_PAOFF_US * 1000) / `RSDP_CLK_NS)
`define RSDP_CYC_RXCAL ((`RSDP_T_RXCAL_US * 1000) / `RSDP_CLK_NS)
`define RSDP_CYC_TXSTART ((`RSDP_T_TXSTART_MIN_NS + `RSDP_CLK_NS - 1) / `RSDP_CLK_NS)
`define RSDP_CYC_US (1000 / `RSDP_CLK_NS)

`endif

/* File: test/rsdp_core_sva.sv */
/* Checker for the serial data port timing block.
   Assumes sys_clk with srst synchronous active high. */
`timescale 1ns/1ps
module rsdp_core_sva #(
	parameter SYM_CYC = 20
) (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Commands and events
	input wire pan_mode,
	input wire transmit_command,
	input wire receive_command,
	input wire phy_ready_command,
	input wire pa_nominal,
	input wire frame_done,
	input wire sync_det,
	// Outputs
	input wire serial_data_clock_out_ff,
	input wire frame_sync_out_ff,
	input wire pkt_irq_ff,
	input wire pa_on_ff,
	input wire tx_state_ff,
	input wire rx_state_ff
);
	localparam int FS_LO = 4 * SYM_CYC;
	localparam int FS_HI = 6 * SYM_CYC;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	reg [15:0] cmd_cnt_ff;
	reg [15:0] lo_cnt_ff;
	// Cycles since an accepted command, low time of the serial clock
	always @(posedge sys_clk) begin
		if (srst || ((transmit_command || receive_command) && !rx_state_ff && !tx_state_ff))
			cmd_cnt_ff <= 16'h0000;
		else
			cmd_cnt_ff <= cmd_cnt_ff + 16'h0001;
		lo_cnt_ff <= serial_data_clock_out_ff ? 16'h0000 : lo_cnt_ff + 16'h0001;
	end
	property p_irq;
		frame_done |-> ##[380:381] pkt_irq_ff;
	endproperty
	a_irq: assert property (p_irq) else $error("late packet interrupt");
	property p_irq_pulse;
		pkt_irq_ff |=> !pkt_irq_ff;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
	property p_turn;
		$rose(rx_state_ff) || $rose(tx_state_ff) |-> cmd_cnt_ff >= (pan_mode ? 16'd1920 : 16'd6640);
	endproperty
	a_turn: assert property (p_turn) else $error("turnaround too short");
	property p_clk_off;
		phy_ready_command && rx_state_ff |-> ##142 !serial_data_clock_out_ff [*8];
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock still running");
	property p_pa_off;
		phy_ready_command && tx_state_ff |-> ##[99:101] !pa_on_ff;
	endproperty
	a_pa_off: assert property (p_pa_off) else $error("amplifier still on");
	property p_period;
		$rose(serial_data_clock_out_ff) && lo_cnt_ff <= SYM_CYC |-> lo_cnt_ff == SYM_CYC / 2;
	endproperty
	a_period: assert property (p_period) else $error("clock low half wrong");
	property p_fsync;
		sync_det && rx_state_ff |-> ##[FS_LO:FS_HI] $rose(frame_sync_out_ff);
	endproperty
	a_fsync: assert property (p_fsync) else $error("frame sync late");
	property p_tx_start;
		$rose(tx_state_ff) |-> $past(pa_nominal, 13);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("transmit entered early");
	property p_rst;
		disable iff (1'b0) srst |=> !pkt_irq_ff && !pa_on_ff && !tx_state_ff && !rx_state_ff;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // rsdp_core_sva

/* File: test/rsdp_core_tb.sv */
/* Testbench for the serial data port timing block.
   Assumes rsdp_core, rsdp_host and the checker are compiled alongside. */
`timescale 1ns/1ps
`include "rsdp_regs.vh"
module rsdp_core_tb;
	localparam SYM = 8;
	reg sys_clk = 1'b0;
	reg srst = 1'b1;
	reg reg_wr = 1'b0;
	reg [11:0] reg_addr = 12'h000;
	reg [7:0] reg_wdata = 8'h00;
	reg pan_mode = 1'b1;
	reg pa_nominal = 1'b0;
	reg rx_bit = 1'b0;
	reg [5:0] ev = 6'h00;
	wire [7:0] reg_rdata_ff;
	wire [15:0] rx_count;
	wire serial_tx_data_in, serial_rx_data_out_ff, serial_data_clock_out_ff, frame_sync_out_ff;
	wire pkt_irq_ff, pa_on_ff, tx_state_ff, rx_state_ff, data_valid_ff, tx_bit_valid_ff, tx_bit_ff;
	int n_fail = 0;
	int checks = 0;
	int cyc;
	int tx_bits = 0;
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		rx_bit <= ~rx_bit;
		if (tx_bit_valid_ff === 1'b1)
			tx_bits++;
	end
	rsdp_core #(.SYM_CYC(SYM), .SYNC_LEN(16)) dut (.sys_clk, .srst, .reg_wr, .reg_addr, .reg_wdata,
		.reg_rdata_ff, .pan_mode, .transmit_command(ev[0]), .receive_command(ev[1]),
		.phy_ready_command(ev[2]), .pa_nominal, .frame_done(ev[3]), .preamble_det(ev[4]),
		.sync_det(ev[5]), .rx_bit, .serial_tx_data_in, .serial_rx_data_out_ff,
		.serial_data_clock_out_ff, .frame_sync_out_ff, .pkt_irq_ff, .pa_on_ff, .tx_state_ff,
		.rx_state_ff, .data_valid_ff, .tx_bit_valid_ff, .tx_bit_ff);
	rsdp_host host (.sys_clk, .serial_data_clock_out_ff, .serial_rx_data_out_ff,
		.serial_tx_data_in, .rx_count_ff(rx_count));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (exp !== got) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input [11:0] a, input [7:0] d);
		@(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input [11:0] a, input [7:0] exp);
		@(posedge sys_clk) reg_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1 chk("register read", {8'h00, exp}, {8'h00, reg_rdata_ff});
	endtask
	task automatic pulse(input int k);
		@(posedge sys_clk) ev <= 6'h01 << k;
		@(posedge sys_clk) ev <= 6'h00;
		cyc = 0;
	endtask
	task automatic t_regs;
		rd(`RSDP_OFS_TURNAROUND_EXT, `RSDP_RST_TURNAROUND_EXT);
		rd(`RSDP_OFS_CTRL_CFG, `RSDP_RST_CTRL_CFG);
		rd(`RSDP_OFS_PIN_FUNC, `RSDP_RST_PIN_FUNC);
		rd(12'h000, 8'h00);
		wr(`RSDP_OFS_TURNAROUND_EXT, 8'h5a);
		rd(`RSDP_OFS_TURNAROUND_EXT, 8'h5a);
	endtask
	task automatic t_rx;
		wr(`RSDP_OFS_TURNAROUND_EXT, 8'h00);
		wr(`RSDP_OFS_CTRL_CFG, `RSDP_MODE_SERIAL);
		wr(`RSDP_OFS_PIN_FUNC, `RSDP_PF_RISE_NOGATE);
		pulse(1);
		while (rx_state_ff !== 1'b1 && cyc < 4000) begin @(posedge sys_clk); cyc++; end
		chk("rx entry", 1, cyc >= 2968 && cyc <= 2975);
		repeat (12 * SYM) @(posedge sys_clk);
		chk("clock active", 1, rx_count >= 16'd10);
		pulse(5);
		while (frame_sync_out_ff !== 1'b1 && cyc < 200) begin @(posedge sys_clk); cyc++; end
		chk("frame sync", 1, cyc >= 4 * SYM && cyc <= 6 * SYM);
		pulse(3);
		while (pkt_irq_ff !== 1'b1 && cyc < 500) begin @(posedge sys_clk); cyc++; end
		chk("irq delay", 1, cyc >= 380 && cyc <= 381);
		chk("data valid", 1, data_valid_ff);
		pulse(2);
		repeat (150) @(posedge sys_clk);
		cyc = rx_count;
		repeat (5 * SYM) @(posedge sys_clk);
		chk("clock stopped", cyc, rx_count);
		repeat (300) @(posedge sys_clk);
	endtask
	task automatic t_tx;
		pan_mode <= 1'b0;
		pulse(0);
		wr(`RSDP_OFS_TURNAROUND_EXT, 8'h02);
		while (pa_on_ff !== 1'b1 && cyc < 9000) begin @(posedge sys_clk); cyc++; end
		chk("tx turnaround", 1, cyc >= 6658 && cyc < 9000);
		pa_nominal <= 1'b1;
		pulse(4);
		while (tx_state_ff !== 1'b1 && cyc < 100) begin @(posedge sys_clk); cyc++; end
		chk("tx entry", 1, cyc >= 11 && cyc <= 62);
		repeat (10 * SYM) @(posedge sys_clk);
		chk("tx sampled", 1, tx_bits > 0);
		pulse(2);
		while (pa_on_ff !== 1'b0 && cyc < 300) begin @(posedge sys_clk); cyc++; end
		chk("pa off", 1, cyc >= 100 && cyc <= 101);
		pa_nominal <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs;
		t_rx;
		t_tx;
		wrap_up;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_fail++;
		wrap_up;
	end
endmodule // rsdp_core_tb
bind rsdp_core rsdp_core_sva #(.SYM_CYC(SYM_CYC)) u_sva (.sys_clk, .srst, .pan_mode, .transmit_command,
	.receive_command, .phy_ready_command, .pa_nominal, .frame_done, .sync_det, .serial_data_clock_out_ff,
	.frame_sync_out_ff, .pkt_irq_ff, .pa_on_ff, .tx_state_ff, .rx_state_ff);

/* File: test/rsdp_host.sv */
/* Host serial port model: samples receive data on rising clock edges.
   Assumes the serial clock is a registered level on sys_clk. */
`timescale 1ns/1ps
module rsdp_host (
	// Clock
	input wire sys_clk,
	// Serial pins
	input wire serial_data_clock_out_ff,
	input wire serial_rx_data_out_ff,
	output reg serial_tx_data_in,
	// Observed
	output reg [15:0] rx_count_ff
);
	reg clk_d_ff = 1'b0;
	reg [7:0] rx_shift_ff = 8'h00;
	initial begin
		serial_tx_data_in = 1'b0;
		rx_count_ff = 16'h0000;
	end
	always @(posedge sys_clk) begin
		clk_d_ff <= serial_data_clock_out_ff;
		if (serial_data_clock_out_ff && !clk_d_ff) begin
			rx_shift_ff <= {rx_shift_ff[6:0], serial_rx_data_out_ff};
			rx_count_ff <= rx_count_ff + 16'h0001;
		end
		// New bit after the falling edge, held over the rising one
		if (!serial_data_clock_out_ff && clk_d_ff) begin
			serial_tx_data_in <= ~serial_tx_data_in;
		end
	end
endmodule // rsdp_host
